// File: verilog/serial_voice_dram_bridge.sv
// Notes on behaviour
// - Address bits shift in on host clock
// - Transfer strobe loads address into counter
// - Read: DRAM bit latched, driven to host
// - Write: host data bit written to DRAM
// - Each strobe fall advances counter, new address
// - Self refresh with row-strobe-only cycles
// - Mode 0: select 1, eight 1M-bit strobes
// - Mode 1: select n drives strobe pair
// - Mode 2: strobe 1 big, 2-4 small
// - Mode 3: selects pairwise onto two strobes
// - Modes 1 and 3: each select reaches 8M-bit, 32M total
// - 16M-bit parts: selects give top address
// - Plain row/column cycles, no static column
`timescale 1ns/1ps
`default_nettype none

module serial_voice_dram_bridge
    import dram_bridge_pkg::*;
(
    input  wire logic                CLK_IN,
    input  wire logic                RESET_IN,
    input  wire logic                ADDR_SHIFT_CLK_IN,
    input  wire logic                SERIAL_ADDR_IN,
    input  wire logic                ADDR_XFER_STROBE_IN,
    input  wire logic                ACCESS_STROBE_N_IN,
    input  wire logic                WRITE_SEL_N_IN,
    input  wire logic                HOST_SERIAL_DATA_IN,
    input  wire logic [CS_N-1:0]     CHIP_SEL_N_IN,
    input  wire logic                CONFIG_SEL_LO_IN,
    input  wire logic                CONFIG_SEL_HI_IN,
    input  wire logic                DRAM_BIT_IN,
    output logic                     HOST_READ_DATA_OUT,
    output logic      [DRAM_A_W-1:0] DRAM_ADDR_OUT,
    output logic                     DRAM_ROW_STROBE_N_OUT,
    output logic      [CAS_N-1:0]    DRAM_COL_STROBE_N_OUT,
    output logic                     DRAM_WRITE_STROBE_N_OUT,
    output logic                     DRAM_DATA_OUT
);

    // Row and column halves of the sample address for each arrangement
    function automatic logic [2*DRAM_A_W-1:0] split_addr(input dram_cfg_t       cfg,
                                                         input logic [ADDR_W-1:0] a,
                                                         input logic [CS_N-1:0]   cs_n);
        logic [DRAM_A_W-1:0] r;
        logic [DRAM_A_W-1:0] c;
        r = '0;
        c = '0;
        case (cfg)
            CFG_1M: begin
                r[ROW_W_1M-1:0] = a[ROW_W_1M-1:0];
                c[ROW_W_1M-1:0] = a[2*ROW_W_1M-1:ROW_W_1M];
            end
            CFG_4M: begin
                r[ROW_W_4M-1:0] = a[ROW_W_4M-1:0];
                c[ROW_W_4M-1:0] = a[2*ROW_W_4M-1:ROW_W_4M];
            end
            CFG_MIX: begin
                if (!a[MIX_SEL_BIT]) begin
                    r[ROW_W_4M-1:0] = a[ROW_W_4M-1:0];
                    c[ROW_W_4M-1:0] = a[2*ROW_W_4M-1:ROW_W_4M];
                end else begin
                    r[ROW_W_1M-1:0] = a[ROW_W_1M-1:0];
                    c[ROW_W_1M-1:0] = a[2*ROW_W_1M-1:ROW_W_1M];
                end
            end
            CFG_16M: begin
                // Second and fourth selects name the upper half of a part
                r = a[ROW_W_16M-1:0];
                c = {(!cs_n[1] || !cs_n[3]), a[ADDR_W-1:ROW_W_16M]};
            end
            default: begin
                r = '0;
                c = '0;
            end
        endcase
        return {r, c};
    endfunction

    // Which column strobe serves this address and select, active high
    function automatic logic [CAS_N-1:0] cas_decode(input dram_cfg_t         cfg,
                                                    input logic [ADDR_W-1:0] a,
                                                    input logic [CS_N-1:0]   cs_n);
        logic [CAS_N-1:0] s;
        logic [1:0]       small_idx;
        int               i;
        s = '0;
        small_idx = a[BANK_LSB_1M+1:BANK_LSB_1M];
        case (cfg)
            CFG_1M: begin
                if (!cs_n[0]) begin
                    s[a[ADDR_W-1:BANK_LSB_1M]] = 1'b1;
                end
            end
            CFG_4M: begin
                for (i = 0; i < CS_N; i++) begin
                    if (!cs_n[i] && (s == '0)) begin
                        s[2*i + int'(a[PAIR_BIT_4M])] = 1'b1;
                    end
                end
            end
            CFG_MIX: begin
                if (!cs_n[0]) begin
                    if (!a[MIX_SEL_BIT]) begin
                        s[0] = 1'b1;
                    end else if (int'(small_idx) < MIX_SMALL_MAX) begin
                        s[int'(small_idx) + 1] = 1'b1;
                    end
                end
            end
            CFG_16M: begin
                if (!cs_n[0] || !cs_n[1]) begin
                    s[0] = 1'b1;
                end else if (!cs_n[2] || !cs_n[3]) begin
                    s[1] = 1'b1;
                end
            end
            default: begin
                s = '0;
            end
        endcase
        return s;
    endfunction

    pin_sample_t         pin_raw;
    pin_sample_t         pin_s;
    pin_sample_t         pin_d_ff;
    logic [ADDR_W-1:0]   shift_val;
    logic                xfer_rise;
    logic                strobe_fall;
    dram_cfg_t           cfg;

    seq_state_t          state_ff,     nxt_state;
    logic [TMR_W-1:0]    tmr_ff,       nxt_tmr;
    logic [TMR_W-1:0]    ref_tmr_ff,   nxt_ref_tmr;
    logic                ref_pend_ff,  nxt_ref_pend;
    logic                acc_pend_ff,  nxt_acc_pend;
    logic                acc_write_ff, nxt_acc_write;
    logic                acc_wdata_ff, nxt_acc_wdata;
    logic [ADDR_W-1:0]   addr_cnt_ff,  nxt_addr_cnt;
    logic [DRAM_A_W-1:0] ref_row_ff,   nxt_ref_row;
    logic [DRAM_A_W-1:0] col_ff,       nxt_col;
    logic [CAS_N-1:0]    cas_sel_ff,   nxt_cas_sel;
    logic                rdata_ff,     nxt_rdata;
    dram_drive_t         drive_ff,     nxt_drive;
    logic [2*DRAM_A_W-1:0] rc;

    // Every host pin but the shift clock and serial address crosses two flops before use
    assign pin_raw = '{xfer: ADDR_XFER_STROBE_IN, strobe_n: ACCESS_STROBE_N_IN,
                       write_n: WRITE_SEL_N_IN, cs_n: CHIP_SEL_N_IN,
                       cfg: {CONFIG_SEL_HI_IN, CONFIG_SEL_LO_IN},
                       wdata: HOST_SERIAL_DATA_IN, rdata: DRAM_BIT_IN};

    pin_sync_2ff #(
        .W       ($bits(pin_sample_t)),
        .RST_VAL (PIN_RST)
    ) u_pin_sync (
        .clk_in (CLK_IN),
        .rst_in (RESET_IN),
        .d_in   (pin_raw),
        .q_out  (pin_s)
    );

    // Serial address lives on the host's shift clock
    addr_shift_reg #(
        .W (ADDR_W)
    ) u_shift (
        .shift_clk_in  (ADDR_SHIFT_CLK_IN),
        .serial_in     (SERIAL_ADDR_IN),
        .shift_val_out (shift_val)
    );

    // Edge detection on the synchronised copies only
    assign xfer_rise   = pin_s.xfer & ~pin_d_ff.xfer;
    assign strobe_fall = ~pin_s.strobe_n & pin_d_ff.strobe_n;
    assign cfg         = dram_cfg_t'(pin_s.cfg);
    assign rc          = split_addr(cfg, addr_cnt_ff, pin_s.cs_n);

    // Sequencer, counters and request flags
    always_comb begin
        nxt_state     = state_ff;
        nxt_tmr       = tmr_ff;
        nxt_ref_tmr   = ref_tmr_ff;
        nxt_acc_write = acc_write_ff;
        nxt_acc_wdata = acc_wdata_ff;
        nxt_addr_cnt  = addr_cnt_ff;
        nxt_ref_row   = ref_row_ff;
        nxt_col       = col_ff;
        nxt_cas_sel   = cas_sel_ff;
        nxt_rdata     = rdata_ff;
        nxt_drive     = drive_ff;
        nxt_drive.cas_n = '1;
        nxt_drive.we_n  = 1'b1;
        nxt_drive.wdata = acc_wdata_ff;

        // Refresh interval timer; a new request beats the clear
        if (ref_tmr_ff == '0) begin
            nxt_ref_tmr = TMR_W'(REF_INT_CYC - 1);
        end else begin
            nxt_ref_tmr = ref_tmr_ff - 1'b1;
        end
        nxt_ref_pend = ref_pend_ff | (ref_tmr_ff == '0);

        // Strobe fall books an access and samples mode and data
        nxt_acc_pend = acc_pend_ff | strobe_fall;
        if (strobe_fall) begin
            nxt_acc_write = ~pin_s.write_n;
            nxt_acc_wdata = pin_s.wdata;
        end

        case (state_ff)
            ST_IDLE: begin
                nxt_drive.ras_n = 1'b1;
                // Refresh first; a booked access waits, never dropped
                if (ref_pend_ff) begin
                    nxt_ref_pend    = (ref_tmr_ff == '0);
                    nxt_state       = ST_REF;
                    nxt_tmr         = TMR_W'(RRAS_CYC - 1);
                    nxt_drive.addr  = ref_row_ff;
                    nxt_drive.ras_n = 1'b0;
                end else if (acc_pend_ff) begin
                    nxt_acc_pend   = strobe_fall;
                    nxt_state      = ST_ROW;
                    nxt_tmr        = TMR_W'(ASR_CYC + RAH_CYC - 1);
                    nxt_drive.addr = rc[2*DRAM_A_W-1:DRAM_A_W];
                    nxt_col        = rc[DRAM_A_W-1:0];
                    nxt_cas_sel    = cas_decode(cfg, addr_cnt_ff, pin_s.cs_n);
                end
            end
            ST_ROW: begin
                // Row address settles before the row strobe falls
                nxt_drive.ras_n = (tmr_ff > TMR_W'(RAH_CYC));
                if (tmr_ff == '0) begin
                    nxt_state       = ST_COL;
                    nxt_tmr         = TMR_W'(CAS_CYC - 1);
                    nxt_drive.addr  = col_ff;
                    nxt_drive.cas_n = ~cas_sel_ff;
                    nxt_drive.we_n  = ~acc_write_ff;
                end else begin
                    nxt_tmr = tmr_ff - 1'b1;
                end
            end
            ST_COL: begin
                nxt_drive.ras_n = 1'b0;
                if (tmr_ff == '0) begin
                    // End of the single column pulse: latch, step, precharge
                    if (!acc_write_ff) begin
                        nxt_rdata = pin_s.rdata;
                    end
                    nxt_addr_cnt    = addr_cnt_ff + 1'b1;
                    nxt_state       = ST_PRE;
                    nxt_tmr         = TMR_W'(RP_CYC - 1);
                    nxt_drive.ras_n = 1'b1;
                end else begin
                    nxt_tmr         = tmr_ff - 1'b1;
                    nxt_drive.cas_n = ~cas_sel_ff;
                    nxt_drive.we_n  = ~acc_write_ff;
                end
            end
            ST_PRE: begin
                nxt_drive.ras_n = 1'b1;
                if (tmr_ff == '0) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_tmr = tmr_ff - 1'b1;
                end
            end
            ST_REF: begin
                // Row strobe only; column strobes stay high
                nxt_drive.ras_n = 1'b0;
                if (tmr_ff == '0) begin
                    nxt_ref_row     = ref_row_ff + 1'b1;
                    nxt_state       = ST_PRE;
                    nxt_tmr         = TMR_W'(RP_CYC - 1);
                    nxt_drive.ras_n = 1'b1;
                end else begin
                    nxt_tmr = tmr_ff - 1'b1;
                end
            end
            default: begin
                nxt_state       = ST_IDLE;
                nxt_drive.ras_n = 1'b1;
            end
        endcase

        // Host load wins over a step; the shift register is quiet here
        if (xfer_rise) begin
            nxt_addr_cnt = shift_val;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            state_ff     <= ST_IDLE;
            tmr_ff       <= '0;
            ref_tmr_ff   <= TMR_W'(REF_INT_CYC - 1);
            ref_pend_ff  <= 1'b0;
            acc_pend_ff  <= 1'b0;
            acc_write_ff <= 1'b0;
            acc_wdata_ff <= 1'b0;
            addr_cnt_ff  <= '0;
            ref_row_ff   <= '0;
            col_ff       <= '0;
            cas_sel_ff   <= '0;
            rdata_ff     <= 1'b0;
            drive_ff     <= '{ras_n: 1'b1, cas_n: '1, we_n: 1'b1, addr: '0, wdata: 1'b0};
            pin_d_ff     <= PIN_RST;
        end else begin
            state_ff     <= nxt_state;
            tmr_ff       <= nxt_tmr;
            ref_tmr_ff   <= nxt_ref_tmr;
            ref_pend_ff  <= nxt_ref_pend;
            acc_pend_ff  <= nxt_acc_pend;
            acc_write_ff <= nxt_acc_write;
            acc_wdata_ff <= nxt_acc_wdata;
            addr_cnt_ff  <= nxt_addr_cnt;
            ref_row_ff   <= nxt_ref_row;
            col_ff       <= nxt_col;
            cas_sel_ff   <= nxt_cas_sel;
            rdata_ff     <= nxt_rdata;
            drive_ff     <= nxt_drive;
            pin_d_ff     <= pin_s;
        end
    end

    // All pins come straight from flops
    assign HOST_READ_DATA_OUT      = rdata_ff;
    assign DRAM_ADDR_OUT           = drive_ff.addr;
    assign DRAM_ROW_STROBE_N_OUT   = drive_ff.ras_n;
    assign DRAM_COL_STROBE_N_OUT   = drive_ff.cas_n;
    assign DRAM_WRITE_STROBE_N_OUT = drive_ff.we_n;
    assign DRAM_DATA_OUT           = drive_ff.wdata;

    // Checks on the core sequencing
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    a_xfer_loads_count: assert property (xfer_rise |=>
        addr_cnt_ff == $past(shift_val))
        else $error("address counter not loaded on transfer strobe");

    a_count_steps: assert property ((state_ff == ST_COL && tmr_ff == '0 && !xfer_rise) |=>
        addr_cnt_ff == ADDR_W'($past(addr_cnt_ff) + 1'b1))
        else $error("address counter did not advance after access");

    a_read_bit_out: assert property ((state_ff == ST_COL && tmr_ff == '0 && !acc_write_ff) |=>
        rdata_ff == $past(pin_s.rdata))
        else $error("read bit not latched to host");

    a_write_gated: assert property (!drive_ff.we_n |->
        acc_write_ff && (drive_ff.cas_n != '1) && (drive_ff.wdata == acc_wdata_ff))
        else $error("write strobe outside a write column pulse");

    a_refresh_ras_only: assert property ((state_ff == ST_REF) |->
        (drive_ff.cas_n == '1) && drive_ff.we_n && !drive_ff.ras_n)
        else $error("column activity during refresh");

    a_ras_width: assert property ($fell(drive_ff.ras_n) |-> (!drive_ff.ras_n)[*7])
        else $error("row strobe pulse too short");

    a_one_column: assert property ($onehot0(~drive_ff.cas_n) && ((drive_ff.cas_n == '1)
        || !drive_ff.ras_n))
        else $error("column strobe not a single pulse inside row strobe");

    a_access_served: assert property (acc_pend_ff |-> ##[1:24] (state_ff == ST_ROW))
        else $error("booked access not started");

    a_refresh_served: assert property (ref_pend_ff |-> ##[1:24] (state_ff == ST_REF))
        else $error("refresh request not served");

    a_cas_in_mode1: assert property ((state_ff == ST_ROW && cfg == CFG_4M && !pin_s.cs_n[0]
        && $stable(pin_s.cs_n) && $past(state_ff) == ST_IDLE) |->
        (cas_sel_ff[1:0] != 2'h0))
        else $error("first select not mapped to first strobe pair");

    c_write_access: cover property (state_ff == ST_COL && acc_write_ff);
    c_read_access:  cover property (state_ff == ST_COL && !acc_write_ff);
    c_refresh:      cover property (state_ff == ST_REF);
    c_collision:    cover property (acc_pend_ff && ref_pend_ff);

endmodule

`default_nettype wire

// File: verilog/dram_bridge_pkg.sv
package dram_bridge_pkg;

    // Core clock rate used to turn times into cycle counts
    localparam int CLK_MHZ      = 10;

    // Widths of the sample address and the DRAM side
    localparam int ADDR_W       = 23;   // 8M-bit reach behind one chip select
    localparam int DRAM_A_W     = 12;   // Multiplexed address lines
    localparam int CAS_N        = 8;    // Column strobe outputs
    localparam int CS_N         = 4;    // Chip select inputs
    localparam int TMR_W        = 8;

    // Address field layout per part size
    localparam int ROW_W_1M     = 10;
    localparam int ROW_W_4M     = 11;
    localparam int ROW_W_16M    = 12;
    localparam int BANK_LSB_1M  = 2 * ROW_W_1M;     // Part index above a 1M-bit span
    localparam int PAIR_BIT_4M  = 2 * ROW_W_4M;     // Second part of a strobe pair
    localparam int MIX_SEL_BIT  = 2 * ROW_W_4M;     // Above the 4M-bit part
    localparam int MIX_SMALL_MAX = 3;               // 1M-bit parts beside the 4M-bit one

    // Strobe timing in ns
    localparam int T_ASR_NS     = 125;
    localparam int T_RAH_NS     = 125;
    localparam int T_CAS_NS     = 500;
    localparam int T_RP_NS      = 125;
    localparam int T_RRAS_NS    = 1000;
    localparam int T_RRC_NS     = 8000;

    // Least time rounds up, longest time rounds down, never below one cycle
    function automatic int ns_min(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int ns_max(input int ns);
        int c;
        c = (ns * CLK_MHZ) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int ASR_CYC      = ns_min(T_ASR_NS);
    localparam int RAH_CYC      = ns_min(T_RAH_NS);
    localparam int CAS_CYC      = ns_min(T_CAS_NS);
    localparam int RP_CYC       = ns_min(T_RP_NS);
    localparam int RRAS_CYC     = ns_min(T_RRAS_NS);
    localparam int REF_INT_CYC  = ns_max(T_RRC_NS);

    typedef enum logic [1:0] {
        CFG_1M  = 2'h0,
        CFG_4M  = 2'h1,
        CFG_MIX = 2'h2,
        CFG_16M = 2'h3
    } dram_cfg_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_ROW  = 5'h02,
        ST_COL  = 5'h04,
        ST_PRE  = 5'h08,
        ST_REF  = 5'h10
    } seq_state_t;

    typedef struct packed {
        logic                ras_n;
        logic [CAS_N-1:0]    cas_n;
        logic                we_n;
        logic [DRAM_A_W-1:0] addr;
        logic                wdata;
    } dram_drive_t;

    typedef struct packed {
        logic            xfer;
        logic            strobe_n;
        logic            write_n;
        logic [CS_N-1:0] cs_n;
        logic [1:0]      cfg;
        logic            wdata;
        logic            rdata;
    } pin_sample_t;

    localparam pin_sample_t PIN_RST = '{xfer: 1'b0, strobe_n: 1'b1, write_n: 1'b1,
                                        cs_n: 4'hF, cfg: 2'h0, wdata: 1'b0, rdata: 1'b0};

endpackage

// File: verilog/pin_sync_2ff.sv
`timescale 1ns/1ps
`default_nettype none

module pin_sync_2ff
    import dram_bridge_pkg::*;
#(
    parameter int            W       = 1,
    parameter logic [W-1:0]  RST_VAL = '0
) (
    input  wire logic         clk_in,
    input  wire logic         rst_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] hold_ff;
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_hold;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = d_in;
        nxt_hold = meta_ff;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            meta_ff <= RST_VAL;
            hold_ff <= RST_VAL;
        end else begin
            meta_ff <= nxt_meta;
            hold_ff <= nxt_hold;
        end
    end

    assign q_out = hold_ff;

endmodule

`default_nettype wire

// File: verilog/addr_shift_reg.sv
`timescale 1ns/1ps
`default_nettype none

module addr_shift_reg
    import dram_bridge_pkg::*;
#(
    parameter int W = ADDR_W
) (
    input  wire logic         shift_clk_in,
    input  wire logic         serial_in,
    output logic      [W-1:0] shift_val_out
);

    logic [W-1:0] shift_ff = '0;
    logic [W-1:0] nxt_shift;

    // Most significant bit first; no reset since the host always shifts a
    // full address before loading it; power-up value keeps the check defined
    always_comb begin
        nxt_shift = {shift_ff[W-2:0], serial_in};
    end

    always_ff @(posedge shift_clk_in) begin
        shift_ff <= nxt_shift;
    end

    assign shift_val_out = shift_ff;

    a_shift_takes_bit: assert property (@(posedge shift_clk_in)
        ##1 (shift_ff[0] == $past(serial_in)) && (shift_ff[W-1:1] == $past(shift_ff[W-2:0])))
        else $error("serial address bit not shifted in");

endmodule

`default_nettype wire

// File: tb/dram_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module dram_far_model
    import dram_bridge_pkg::*;
(
    input  wire logic                ras_n_in,
    input  wire logic [CAS_N-1:0]    cas_n_in,
    input  wire logic                we_n_in,
    input  wire logic [DRAM_A_W-1:0] addr_in,
    input  wire logic                data_in,
    output logic                     data_out,
    output int                       cas_idx_out,
    output int                       refresh_cnt_out
);
    logic        mem [logic [26:0]];
    logic [11:0] row;
    logic [26:0] key;
    logic        last     = 1'b0;
    logic        col_seen = 1'b1;

    // Quiet state before the first cycle
    initial begin
        data_out = 1'b0;
        cas_idx_out = 0;
        refresh_cnt_out = 0;
    end

    // Row opens on the row strobe fall, 1 ns past the edge
    always @(negedge ras_n_in) begin
        #1;
        row = addr_in;
        col_seen = 1'b0;
    end

    // A row cycle that saw no column strobe counts as refresh
    always @(posedge ras_n_in) begin
        if (!col_seen)
            refresh_cnt_out++;
    end

    // Column strobe picks part and bit; settle first so we and data land
    always @(cas_n_in) begin
        #1;
        if (~&cas_n_in) begin
            col_seen = 1'b1;
            for (int i = 0; i < CAS_N; i++)
                if (!cas_n_in[i])
                    cas_idx_out = i;
            key = {cas_idx_out[2:0], row, addr_in};
            if (!we_n_in)
                mem[key] = data_in;
            else
                data_out = mem[key];
            last = data_out;
        end else begin
            data_out = ~last;  // Released line has no pull, so no stale value
        end
    end
endmodule

`default_nettype wire

// File: tb/test_serial_voice_dram_bridge.sv
`timescale 1ns/1ps
`default_nettype none

module test_serial_voice_dram_bridge
    import dram_bridge_pkg::*;
;
    logic                clk = 1'b0, rst = 1'b1, sclk = 1'b0, serial_addr_in = 1'b0, xfer = 1'b0;
    logic                acc_n = 1'b1, wr_n = 1'b1, hd = 1'b0, cfg_lo = 1'b0, cfg_hi = 1'b0;
    logic [CS_N-1:0]     cs_n = 4'hE;
    logic                dbit, rd, ras_n, we_n, dout;
    logic [DRAM_A_W-1:0] addr;
    logic [CAS_N-1:0]    cas_n;
    int                  cas_idx, ref_cnt, failures = 0, num_checks = 0, cycles = 0;
    // Case table: mode, selects, start address, expected strobe index
    logic [1:0]          t_cfg [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3, 2'h1};
    logic [CS_N-1:0]     t_cs [6]  = '{4'hE, 4'hB, 4'hE, 4'hD, 4'hB, 4'hE};
    logic [ADDR_W-1:0]   t_a [6]   = '{23'h700005, 23'h400123, 23'h600010, 23'h000ABC,
                                       23'h7FFFFF, 23'h000123};
    int                  t_idx [6] = '{7, 5, 3, 0, 1, 0};

    serial_voice_dram_bridge dut (
        .CLK_IN(clk), .RESET_IN(rst), .ADDR_SHIFT_CLK_IN(sclk), .SERIAL_ADDR_IN(serial_addr_in),
        .ADDR_XFER_STROBE_IN(xfer), .ACCESS_STROBE_N_IN(acc_n), .WRITE_SEL_N_IN(wr_n),
        .HOST_SERIAL_DATA_IN(hd), .CHIP_SEL_N_IN(cs_n), .CONFIG_SEL_LO_IN(cfg_lo),
        .CONFIG_SEL_HI_IN(cfg_hi), .DRAM_BIT_IN(dbit), .HOST_READ_DATA_OUT(rd),
        .DRAM_ADDR_OUT(addr), .DRAM_ROW_STROBE_N_OUT(ras_n), .DRAM_COL_STROBE_N_OUT(cas_n),
        .DRAM_WRITE_STROBE_N_OUT(we_n), .DRAM_DATA_OUT(dout));

    dram_far_model dram (
        .ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n), .addr_in(addr),
        .data_in(dout), .data_out(dbit), .cas_idx_out(cas_idx), .refresh_cnt_out(ref_cnt));

    // Core clock, 100 ns
    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Shift clock runs at 32 ns only inside the frame, MSB first
    task automatic load(input logic [ADDR_W-1:0] v);
        for (int i = ADDR_W - 1; i >= 0; i--) begin
            serial_addr_in = v[i];
            #16 sclk = 1'b1;
            #16 sclk = 1'b0;
        end
        repeat (6) @(negedge clk);
        xfer = 1'b1;
        repeat (4) @(negedge clk);
        xfer = 1'b0;
        repeat (4) @(negedge clk);
    endtask

    // One strobe, 31 cycles apart covers a refresh in front of it
    task automatic access(input logic w, input logic d);
        @(negedge clk);
        acc_n = 1'b0;
        wr_n = ~w;
        hd = d;
        repeat (9) @(negedge clk);
        acc_n = 1'b1;
        hd = ~d;
        repeat (21) @(negedge clk);
    endtask

    // Main sequence: each mode writes two bits, reloads, reads them back
    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({2'h3, 8'hFF}, {ras_n, we_n, cas_n});
        for (int i = 0; i < 6; i++) begin
            {cfg_hi, cfg_lo} = t_cfg[i];
            cs_n = t_cs[i];
            repeat (4) @(negedge clk);
            load(t_a[i]);
            access(1'b1, i[0]);
            access(1'b1, !i[0]);
            load(t_a[i]);
            access(1'b0, 1'b0);
            chk(i[0], rd);
            access(1'b0, 1'b0);
            chk(!i[0], rd);
            chk(t_idx[i], cas_idx);
        end
        chk(1, ref_cnt > 0);
        tally_and_finish();
    end

    // Cuts a hung run short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2500) begin
            failures++;
            tally_and_finish();
        end
    end
endmodule

`default_nettype wire
